// File: shared/sram_port_pkg.sv
package sram_port_pkg;

    // storage shape: wide (2M x 36) by default, narrow is 4M x 18
    localparam int DATA_W_WIDE   = 36;
    // two words per address, so the address has one bit fewer than the
    // word count would need
    localparam int ADDR_W_WIDE   = 20;
    localparam int DATA_W_NARROW = 18;
    localparam int ADDR_W_NARROW = 21;
    localparam int BYTE_W        = 9;
    localparam int BURST_LEN     = 2;

    // read latency in half cycles of the link clock
    localparam int LAT_HALF_PLL_ON  = 5;
    localparam int LAT_HALF_PLL_OFF = 2;
    localparam int PIPE_DEPTH       = LAT_HALF_PLL_ON;

    localparam int SYNC_STAGES = 3;
    localparam int FIFO_DEPTH  = 4;

    localparam int DIR_READ = 1;

    typedef enum logic [2:0] {
        WR_IDLE  = 3'b001,
        WR_WORD0 = 3'b010,
        WR_WORD1 = 3'b100
    } wr_state_e;

endpackage

// File: verilog/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] slots [0:DEPTH-1];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   count;

    wire logic push = i_in_valid & o_in_ready;
    wire logic pop  = o_out_valid & i_out_ready;
    wire logic wr_wrap = (wr_ptr == PTR_W'(DEPTH - 1));
    wire logic rd_wrap = (rd_ptr == PTR_W'(DEPTH - 1));

    assign o_in_ready  = (count != (PTR_W+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data  = slots[rd_ptr];

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            slots[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_wrap ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_wrap ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule // word_fifo

`default_nettype wire

// File: verilog/ddr_two_word_burst_sram_port.sv
`timescale 1ns/1ps
`default_nettype none

module ddr_two_word_burst_sram_port #(
    parameter int DATA_W = sram_port_pkg::DATA_W_WIDE,
    parameter int ADDR_W = sram_port_pkg::ADDR_W_WIDE
) (
    input  wire logic                               i_clk_sys,
    input  wire logic                               i_rst_n,
    input  wire logic                               i_link_clk,
    input  wire logic                               i_link_clk_n,
    input  wire logic                               i_load_strobe_n,
    input  wire logic                               i_read_not_write,
    input  wire logic [ADDR_W-1:0]                  i_addr,
    input  wire logic [DATA_W/sram_port_pkg::BYTE_W-1:0] i_byte_write_mask_n,
    input  wire logic [DATA_W-1:0]                  i_dq,
    input  wire logic                               i_pll_off_select,
    output logic      [DATA_W-1:0]                  o_dq,
    output logic                                    o_dq_oe,
    output logic                                    o_read_valid_flag,
    output logic                                    o_echo_timing_pair,
    output logic                                    o_echo_timing_pair_n,
    output logic                                    o_write_ready
);
    localparam int NBYTE = DATA_W / sram_port_pkg::BYTE_W;
    localparam int BW    = sram_port_pkg::BYTE_W;
    localparam int NS    = sram_port_pkg::SYNC_STAGES;
    localparam int PD    = sram_port_pkg::PIPE_DEPTH;
    // two clocks, strobe, direction and pll select besides the buses
    localparam int IN_W  = 5 + ADDR_W + NBYTE + DATA_W;
    localparam int FW    = 1 + ADDR_W + NBYTE + DATA_W;

    // all pins pass three flops; the first is read only by the second
    logic [IN_W-1:0] pin_sync [0:NS-1];
    wire logic [IN_W-1:0] pin_raw = {i_link_clk, i_link_clk_n,
        i_load_strobe_n, i_read_not_write, i_addr, i_byte_write_mask_n,
        i_dq, i_pll_off_select};

    genvar gs;
    generate
        for (gs = 0; gs < NS; gs++) begin : g_sync
            if (gs == 0) begin : g_first
                always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
                    if (!i_rst_n) begin
                        pin_sync[gs] <= '0;
                    end else begin
                        pin_sync[gs] <= pin_raw;
                    end
                end
            end else begin : g_next
                always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
                    if (!i_rst_n) begin
                        pin_sync[gs] <= '0;
                    end else begin
                        pin_sync[gs] <= pin_sync[gs-1];
                    end
                end
            end
        end
    endgenerate

    wire logic [IN_W-1:0] s2 = pin_sync[NS-2];
    wire logic [IN_W-1:0] s3 = pin_sync[NS-1];

    wire logic              k_s2     = s2[IN_W-1];
    wire logic              k_s3     = s3[IN_W-1];
    wire logic              kb_s2    = s2[IN_W-2];
    wire logic              kb_s3    = s3[IN_W-2];
    wire logic              load_n   = s3[IN_W-3];
    wire logic              dir_rd   = s3[IN_W-4];
    wire logic [ADDR_W-1:0] addr_s   = s3[DATA_W+NBYTE+1 +: ADDR_W];
    wire logic [NBYTE-1:0]  mask_s   = s3[DATA_W+1 +: NBYTE];
    wire logic [DATA_W-1:0] data_s   = s3[1 +: DATA_W];
    wire logic              pll_on_s = s3[0];

    // a clock level counts once the second and third flops agree
    logic k_level;
    logic kb_level;
    wire logic k_stable  = (k_s2 == k_s3);
    wire logic kb_stable = (kb_s2 == kb_s3);
    wire logic k_rise    = k_stable & k_s3 & ~k_level;
    wire logic kb_rise   = kb_stable & kb_s3 & ~kb_level;
    wire logic any_edge  = k_rise | kb_rise;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            k_level  <= 1'b0;
            kb_level <= 1'b0;
        end else begin
            if (k_stable) begin
                k_level <= k_s3;
            end
            if (kb_stable) begin
                kb_level <= kb_s3;
            end
        end
    end

    // command slot: the true rise after a capture is never an address edge
    logic slot_skip;
    wire logic load_seen = k_rise & ~load_n;
    wire logic capture   = load_seen & ~slot_skip;
    wire logic rd_cap    = capture & (dir_rd == 1'(sram_port_pkg::DIR_READ));
    wire logic wr_cap    = capture & (dir_rd != 1'(sram_port_pkg::DIR_READ));

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            slot_skip <= 1'b0;
        end else if (k_rise) begin
            slot_skip <= capture;
        end
    end

    // storage: one entry per burst word, index {address, word}
    logic [DATA_W-1:0] mem [0:(2**(ADDR_W+1))-1];

    // write path
    sram_port_pkg::wr_state_e wr_state;
    sram_port_pkg::wr_state_e next_wr_state;
    logic [ADDR_W-1:0]        wr_addr;

    wire logic take_w0 = (wr_state == sram_port_pkg::WR_WORD0) & k_rise;
    wire logic take_w1 = (wr_state == sram_port_pkg::WR_WORD1) & kb_rise;
    wire logic take_w  = take_w0 | take_w1;

    always_comb begin
        next_wr_state = wr_state;
        case (wr_state)
            sram_port_pkg::WR_IDLE: begin
                if (wr_cap) begin
                    next_wr_state = sram_port_pkg::WR_WORD0;
                end
            end
            sram_port_pkg::WR_WORD0: begin
                if (k_rise) begin
                    next_wr_state = sram_port_pkg::WR_WORD1;
                end
            end
            sram_port_pkg::WR_WORD1: begin
                if (kb_rise) begin
                    next_wr_state = sram_port_pkg::WR_IDLE;
                end
            end
            default: begin
                next_wr_state = sram_port_pkg::WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_state <= sram_port_pkg::WR_IDLE;
            wr_addr  <= '0;
        end else begin
            wr_state <= next_wr_state;
            if (wr_cap) begin
                wr_addr <= addr_s;
            end
        end
    end

    // captured words queue up and drain into the array on their own
    wire logic [FW-1:0] fifo_in = {take_w1, wr_addr, mask_s, data_s};
    wire logic [FW-1:0] fifo_out;
    wire logic          fifo_in_ready;
    wire logic          fifo_out_valid;
    // draining stalls while a read samples the array
    wire logic          drain_ready = ~rd_cap;

    word_fifo #(
        .WIDTH (FW),
        .DEPTH (sram_port_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (take_w),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (fifo_in),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (drain_ready),
        .o_out_data  (fifo_out)
    );

    wire logic              drain     = fifo_out_valid & drain_ready;
    wire logic              dr_sel    = fifo_out[FW-1];
    wire logic [ADDR_W-1:0] dr_addr   = fifo_out[NBYTE+DATA_W +: ADDR_W];
    wire logic [NBYTE-1:0]  dr_mask_n = fifo_out[DATA_W +: NBYTE];
    wire logic [DATA_W-1:0] dr_data   = fifo_out[DATA_W-1:0];

    always_ff @(posedge i_clk_sys) begin
        if (drain) begin
            for (int b = 0; b < NBYTE; b++) begin
                if (!dr_mask_n[b]) begin
                    mem[{dr_addr, dr_sel}][b*BW +: BW] <= dr_data[b*BW +: BW];
                end
            end
        end
    end

    // read path; a read right behind a write to the same address may
    // see old data while that write still sits in the queue
    wire logic [DATA_W-1:0] rd_word0 = mem[{addr_s, 1'b0}];
    wire logic [DATA_W-1:0] rd_word1 = mem[{addr_s, 1'b1}];
    wire logic [2:0] lat_half = pll_on_s ?
        3'(sram_port_pkg::LAT_HALF_PLL_ON) :
        3'(sram_port_pkg::LAT_HALF_PLL_OFF);

    // one stage per half cycle of the link clock
    logic [PD-1:0]       pipe_vld;
    logic [2*DATA_W-1:0] pipe_data [0:PD-1];

    genvar gp;
    generate
        for (gp = 0; gp < PD; gp++) begin : g_pipe
            wire logic ins = rd_cap & (3'(gp) == lat_half - 3'd1);
            wire logic nv  = (gp == PD-1) ? 1'b0 : pipe_vld[(gp+1) % PD];
            always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pipe_vld[gp]  <= 1'b0;
                    pipe_data[gp] <= '0;
                end else if (any_edge) begin
                    pipe_vld[gp]  <= ins | nv;
                    pipe_data[gp] <= ins ? {rd_word1, rd_word0}
                                         : pipe_data[(gp+1) % PD];
                end
            end
        end
    endgenerate

    // output stage
    logic              second_due;
    logic [DATA_W-1:0] second_word;
    wire logic launch0 = any_edge & pipe_vld[0];
    wire logic launch1 = any_edge & second_due;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            second_due        <= 1'b0;
            second_word       <= '0;
            o_dq              <= '0;
            o_dq_oe           <= 1'b0;
            o_read_valid_flag <= 1'b0;
        end else if (any_edge) begin
            second_due  <= launch0;
            second_word <= pipe_data[0][2*DATA_W-1:DATA_W];
            if (launch0) begin
                o_dq <= pipe_data[0][DATA_W-1:0];
            end else if (launch1) begin
                o_dq <= second_word;
            end
            o_dq_oe           <= launch0 | launch1;
            o_read_valid_flag <= launch0 | launch1;
        end
    end

    // echo pair rebuilt from the same edges that launch the data
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_echo_timing_pair   <= 1'b0;
            o_echo_timing_pair_n <= 1'b0;
            o_write_ready        <= 1'b0;
        end else begin
            if (k_rise) begin
                o_echo_timing_pair   <= 1'b1;
                o_echo_timing_pair_n <= 1'b0;
            end else if (kb_rise) begin
                o_echo_timing_pair   <= 1'b0;
                o_echo_timing_pair_n <= 1'b1;
            end
            o_write_ready <= fifo_in_ready;
        end
    end

endmodule // ddr_two_word_burst_sram_port

`default_nettype wire

// File: tb/sram_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sram_port_monitor #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 20
) (
    input wire logic              i_clk_sys,
    input wire logic              i_rst_n,
    input wire logic              i_link_clk,
    input wire logic              i_link_clk_n,
    input wire logic              i_load_strobe_n,
    input wire logic              i_read_not_write,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W/sram_port_pkg::BYTE_W-1:0] i_byte_write_mask_n,
    input wire logic [DATA_W-1:0] i_dq,
    input wire logic              i_pll_off_select,
    input wire logic [DATA_W-1:0] o_dq,
    input wire logic              o_dq_oe,
    input wire logic              o_read_valid_flag,
    input wire logic              o_echo_timing_pair,
    input wire logic              o_echo_timing_pair_n,
    input wire logic              o_write_ready
);
    logic [5:0] since_load;
    logic       last_dir;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            since_load <= 6'h3f;
            last_dir   <= 1'b0;
        end else if (!i_load_strobe_n) begin
            since_load <= 6'h00;
            last_dir   <= i_read_not_write;
        end else if (since_load != 6'h3f) begin
            since_load <= since_load + 6'h01;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    a_oe_flag_match: assert property (o_dq_oe == o_read_valid_flag)
        else $error("oe and valid flag differ");
    a_echo_pair_inv: assert property ($changed(o_echo_timing_pair)
        |-> o_echo_timing_pair_n != o_echo_timing_pair) else $error("echo pair");
    // window widths assume the 160 ns link clock of the bench
    a_echo_half_len: assert property ($changed(o_echo_timing_pair)
        |=> $stable(o_echo_timing_pair)[*6]) else $error("echo too fast");
    a_burst_two_words: assert property ($rose(o_read_valid_flag)
        |-> o_read_valid_flag[*8] ##1 o_read_valid_flag[*8] ##1
            !o_read_valid_flag) else $error("burst length");
    a_word_held: assert property ($rose(o_read_valid_flag)
        |=> $stable(o_dq)[*7]) else $error("read word not held");
    a_lat_short: assert property ($rose(o_read_valid_flag)
        && !i_pll_off_select |-> since_load inside {[12:20]})
        else $error("short latency");
    a_lat_long: assert property ($rose(o_read_valid_flag)
        && i_pll_off_select |-> since_load inside {[21:44]})
        else $error("long latency");
    a_read_only: assert property ($rose(o_dq_oe) |-> last_dir)
        else $error("drive without read");
    a_launch_phase: assert property ($rose(o_read_valid_flag)
        |-> o_echo_timing_pair == !i_pll_off_select) else $error("phase");

    c_read_short: cover property ($rose(o_read_valid_flag) && !i_pll_off_select);
    c_read_long: cover property ($rose(o_read_valid_flag) && i_pll_off_select);
    c_write_cmd: cover property ($fell(i_load_strobe_n) && !i_read_not_write);
endmodule // sram_port_monitor

bind ddr_two_word_burst_sram_port sram_port_monitor #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W)
) mon (
    .i_clk_sys            (i_clk_sys),
    .i_rst_n              (i_rst_n),
    .i_link_clk           (i_link_clk),
    .i_link_clk_n         (i_link_clk_n),
    .i_load_strobe_n      (i_load_strobe_n),
    .i_read_not_write     (i_read_not_write),
    .i_addr               (i_addr),
    .i_byte_write_mask_n  (i_byte_write_mask_n),
    .i_dq                 (i_dq),
    .i_pll_off_select     (i_pll_off_select),
    .o_dq                 (o_dq),
    .o_dq_oe              (o_dq_oe),
    .o_read_valid_flag    (o_read_valid_flag),
    .o_echo_timing_pair   (o_echo_timing_pair),
    .o_echo_timing_pair_n (o_echo_timing_pair_n),
    .o_write_ready        (o_write_ready)
);
`default_nettype wire

// File: tb/sram_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sram_ctl_model #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 6
) (
    input  wire logic              i_clk_sys,
    output logic                   o_link_clk,
    output logic                   o_link_clk_n,
    output logic                   o_load_strobe_n,
    output logic                   o_read_not_write,
    output logic [ADDR_W-1:0]      o_addr,
    output logic [DATA_W/9-1:0]    o_byte_write_mask_n,
    output logic [DATA_W-1:0]      o_dq
);
    assign o_link_clk_n = ~o_link_clk;

    initial begin
        o_link_clk = 1'b0;
        o_load_strobe_n = 1'b1;
        o_read_not_write = 1'b0;
        o_addr = '0;
        o_byte_write_mask_n = '1;
        o_dq = '0;
        #3;
        forever #80 o_link_clk = ~o_link_clk;
    end

    // changes land midway between link edges, clear of the sampling
    task automatic after_edge(input bit rise);
        if (rise) @(posedge o_link_clk);
        else @(negedge o_link_clk);
        repeat (4) @(negedge i_clk_sys);
    endtask

    task automatic command(input bit rd, input logic [ADDR_W-1:0] a,
                           input bit hold);
        after_edge(1'b0);
        o_load_strobe_n = 1'b0;
        o_read_not_write = rd;
        o_addr = a;
        after_edge(1'b1);
        if (hold) after_edge(1'b1);
        // released lines show the inverse so a stale value cannot pass
        o_load_strobe_n = 1'b1;
        o_read_not_write = ~rd;
        o_addr = ~a;
    endtask

    task automatic write_burst(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d0, d1, input logic [DATA_W/9-1:0] m0, m1);
        command(1'b0, a, 1'b0);
        o_dq = d0;
        o_byte_write_mask_n = m0;
        after_edge(1'b1);
        o_dq = d1;
        o_byte_write_mask_n = m1;
        after_edge(1'b0);
        o_dq = ~d1;
        o_byte_write_mask_n = '1;
    endtask
endmodule // sram_ctl_model
`default_nettype wire

// File: tb/ddr_two_word_burst_sram_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_two_word_burst_sram_port_tb;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        pll_off = 1'b0;
    wire         k, k_n, load_n, rnw, oe, flag, echo, echo_n, wr_ready;
    wire [5:0]   addr;
    wire [3:0]   mask_n;
    wire [35:0]  ctl_dq, dq_wire, rd_dq;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          edges = 0;

    assign dq_wire = oe ? rd_dq : ctl_dq;

    sram_ctl_model #(.DATA_W(36), .ADDR_W(6)) ctl (.i_clk_sys(clk_sys),
        .o_link_clk(k), .o_link_clk_n(k_n), .o_load_strobe_n(load_n),
        .o_read_not_write(rnw), .o_addr(addr), .o_byte_write_mask_n(mask_n),
        .o_dq(ctl_dq));
    ddr_two_word_burst_sram_port #(.DATA_W(36), .ADDR_W(6)) uut (
        .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_link_clk(k),
        .i_link_clk_n(k_n), .i_load_strobe_n(load_n), .i_read_not_write(rnw),
        .i_addr(addr), .i_byte_write_mask_n(mask_n), .i_dq(dq_wire),
        .i_pll_off_select(pll_off), .o_dq(rd_dq), .o_dq_oe(oe),
        .o_read_valid_flag(flag), .o_echo_timing_pair(echo),
        .o_echo_timing_pair_n(echo_n), .o_write_ready(wr_ready));

    always #5 clk_sys = ~clk_sys;
    always @(k) edges++;

    task automatic end_of_test();
        if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // the ceiling of 30000 cycles is some 1875 link periods, far above the 15 bursts plus reset
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic chk_word(input logic [35:0] got, exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    function automatic logic [35:0] merge(input logic [35:0] old, nw,
                                          input logic [3:0] m_n);
        merge = old;
        for (int i = 0; i < 4; i++) if (!m_n[i]) merge[i*9 +: 9] = nw[i*9 +: 9];
    endfunction

    task automatic s_read(input logic [5:0] a, input logic [35:0] e0, e1,
                          input int lat, input bit hold);
        int n0;
        int w;
        ctl.command(1'b1, a, hold);
        n0 = edges;
        w = 0;
        while (flag !== 1'b1 && w < 200) begin
            @(negedge clk_sys);
            w++;
        end
        chk_bit((edges - n0) == lat, 1'b1);
        chk_word(rd_dq, e0);
        @(k);
        repeat (5) @(negedge clk_sys);
        chk_word(rd_dq, e1);
        chk_bit(echo, pll_off);
        @(k);
        repeat (5) @(negedge clk_sys);
        chk_bit(flag, 1'b0);
        chk_bit(oe, 1'b0);
    endtask

    task automatic s_basic(input bit pll);
        logic [35:0] d0;
        logic [5:0]  a;
        d0 = 36'h123456789 ^ {36{pll}};
        a = pll ? 6'h3f : 6'h00;
        pll_off = pll;
        repeat (20) @(negedge clk_sys);
        ctl.write_burst(a, d0, ~d0 ^ 36'h0f0f0f0f0, 4'h0, 4'h0);
        s_read(a, d0, ~d0 ^ 36'h0f0f0f0f0, pll ? 5 : 2, 1'b0);
    endtask

    task automatic s_mask();
        pll_off = 1'b0;
        ctl.write_burst(6'h0a, 36'h111111111, 36'h222222222,
                        4'h0, 4'h0);
        ctl.write_burst(6'h0a, 36'h9abcdef01, 36'h3c3c3c3c3,
                        4'h5, 4'ha);
        s_read(6'h0a, merge(36'h111111111, 36'h9abcdef01, 4'h5),
               merge(36'h222222222, 36'h3c3c3c3c3, 4'ha), 2, 1'b0);
        chk_bit(wr_ready, 1'b1);
        pll_off = 1'b1;
        repeat (20) @(negedge clk_sys);
        s_read(6'h0a, merge(36'h111111111, 36'h9abcdef01, 4'h5),
               merge(36'h222222222, 36'h3c3c3c3c3, 4'ha), 3, 1'b1);
    endtask

    // back-to-back bursts pass the write queue in order; a fully masked
    // burst must leave the stored words alone
    task automatic s_queue();
        repeat (20) @(negedge clk_sys);
        for (int i = 1; i < 4; i++) begin
            ctl.write_burst(6'(i), {9{4'(i)}}, {9{4'(~i)}},
                            4'h0, 4'h0);
            chk_bit(wr_ready, 1'b1);
        end
        ctl.write_burst(6'h01, 36'h0, 36'h0, 4'hf, 4'hf);
        for (int i = 1; i < 4; i++) begin
            s_read(6'(i), {9{4'(i)}}, {9{4'(~i)}}, 2, 1'b0);
        end
        chk_bit(oe, 1'b0);
    endtask

    initial begin
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        s_queue();
        s_basic(1'b0);
        s_basic(1'b1);
        s_mask();
        end_of_test();
    end
endmodule // ddr_two_word_burst_sram_port_tb
`default_nettype wire
